// ---- logic/ofpl_regs.svh ----
// offsets, field positions, reset values and timing counts of the fault latch
// assumes inclusion by bare name from the slew divider, the core module and the bench
`ifndef OFPL_REGS_SVH
`define OFPL_REGS_SVH

// register byte addresses on the plain register port
`define OFPL_ADDR_STATUS 8'h00
`define OFPL_ADDR_MASK 8'h04
`define OFPL_ADDR_STATE 8'h08
`define OFPL_ADDR_SLEWDIV 8'h0C

// event bits, shared by status and mask
`define OFPL_EV_OV 0
`define OFPL_EV_UV 1
`define OFPL_EV_TH 2
`define OFPL_EV_TEST 3
`define OFPL_EV_W 4

// state register bits (read only)
`define OFPL_ST_OV 0
`define OFPL_ST_UV 1
`define OFPL_ST_TH 2
`define OFPL_ST_TEST 3
`define OFPL_ST_BLANK 4
`define OFPL_ST_LIMFIX 5
`define OFPL_ST_SHUTDOWN 6
`define OFPL_ST_MOD 7

// reset values
`define OFPL_STATUS_RST 4'h0
`define OFPL_MASK_RST 4'h0
`define OFPL_UNMAPPED 32'h0000_0000

// timing: clock period and default slew clock period in ns
`define OFPL_CLK_NS 20
`define OFPL_SLEW_NS 3125
`define OFPL_SLEW_DIV_RST 16'((`OFPL_SLEW_NS) / (`OFPL_CLK_NS))
`define OFPL_BLANK_TICKS 6'h20

`endif

// ---- logic/ofpl_pkg.sv ----
// types shared by the fault latch files
// assumes the constant header sits beside it
package ofpl_pkg;

  // one bit per protection source; used for raw trips and latched faults
  typedef struct packed {
    logic ov;
    logic uv;
    logic th;
  } ofpl_trip_s;

  // output transition blanking states
  typedef enum logic [1:0] {
    BLK_IDLE,
    BLK_SLEW,
    BLK_SETTLE
  } ofpl_blank_e;

  typedef logic [15:0] ofpl_div_t;

endpackage

// ---- logic/ofpl_sync.sv ----
// two-flop synchroniser for the three protection comparator levels
// assumes comparator outputs are slow levels, asynchronous to clk
`timescale 1ns/100ps
module ofpl_sync
  import ofpl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire ofpl_trip_s async_in,
  output ofpl_trip_s sync_out
);

  ofpl_trip_s meta_ff;
  ofpl_trip_s sync_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ---- logic/ofpl_slew_div.sv ----
// divider giving the slew-rate clock as a one-cycle enable pulse
// assumes the divide value is set by software; zero behaves as one
`timescale 1ns/100ps
`include "ofpl_regs.svh"
module ofpl_slew_div
  import ofpl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire ofpl_div_t div,
  output logic tick
);

  ofpl_div_t cnt_ff;
  ofpl_div_t nxt_cnt;
  wire logic at_end;

  // a new divide value takes effect at the next wrap, never mid-period
  assign at_end = (cnt_ff <= 16'h0001);
  assign nxt_cnt = at_end ? div : cnt_ff - 16'h0001;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= `OFPL_SLEW_DIV_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = at_end;

endmodule

// ---- logic/ofpl_core.sv ----
// output fault protection latch of a step-down core regulator controller
// assumes comparators are asynchronous levels, all other inputs sync to clk;
// srst stands for logic supply power-up (supply below 1V clears everything)
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "ofpl_regs.svh"

// Contract
// - an overvoltage trip beyond the 13 percent margin latches a fault and shuts down.
// - an overvoltage trip at once pulls power-good low and clock-gate request high.
// - after overvoltage the low-side drive stays high until shutdown toggles or power cycles.
// - an undervoltage trip below 70 percent latches the modulator off until toggle or power cycle.
// - undervoltage is ignored during a transition and for 32 slew clocks after it ends.
// - a thermal trip forces the low-side drive high and the high-side drive low.
// - after a thermal fault the block stays off until shutdown toggles or power cycles.
// - the bypass test mode disables all three responses and clears the fault latch.
// - the current-limit select tied to the supply picks the fixed 50mV limit, else adjustable.
// - power-good and clock-gate request hold during a transition and 32 slew clocks after; a raw or latched overvoltage still forces them.
module ofpl_core
  import ofpl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire ofpl_trip_s trip_raw,
  input wire logic shutdown_in,
  input wire logic test_level_detect,
  input wire logic current_limit_select,
  input wire logic transition_busy,
  input wire logic regulator_ok,
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic low_side_drive,
  output logic high_side_drive,
  output logic modulator_enable,
  output logic cpu_power_good,
  output logic clock_gate_request,
  output logic current_limit_fixed,
  output logic irq
);

  // widen a narrow field into a read word, upper bits zero
  function automatic logic [31:0] ofpl_zext8(input logic [7:0] v);
    ofpl_zext8 = {24'h000000, v};
  endfunction

  // ---------------- declarations ----------------
  ofpl_trip_s trip_sync;
  ofpl_trip_s fault_ff;
  ofpl_trip_s nxt_fault;
  ofpl_trip_s fault_set;
  ofpl_blank_e blank_ff;
  ofpl_blank_e nxt_blank;
  ofpl_div_t slew_div_ff;
  logic [5:0] blank_cnt_ff;
  logic [5:0] nxt_blank_cnt;
  logic [`OFPL_EV_W-1:0] status_ff;
  logic [`OFPL_EV_W-1:0] nxt_status;
  logic [`OFPL_EV_W-1:0] mask_ff;
  logic [`OFPL_EV_W-1:0] events;
  logic [31:0] rdata_ff;
  logic shutdown_seen_ff;
  logic test_ff;
  logic pg_ff;
  logic clkreq_ff;
  logic low_ff;
  logic high_ff;
  logic limit_fixed_ff;
  logic nxt_pg;
  logic nxt_clkreq;
  logic nxt_low;
  logic nxt_high;
  wire logic slew_tick;
  wire logic bypass;
  wire logic ov_now;
  wire logic toggle_done;
  wire logic blanked;
  wire logic any_fault;
  wire logic force_low;
  wire logic off_state;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic wr_div;
  wire logic [7:0] state_word;
  wire logic [31:0] rd_mux;

  // ---------------- helpers ----------------
  ofpl_sync u_sync (
    .clk(clk),
    .srst(srst),
    .async_in(trip_raw),
    .sync_out(trip_sync)
  );

  ofpl_slew_div u_div (
    .clk(clk),
    .srst(srst),
    .div(slew_div_ff),
    .tick(slew_tick)
  );

  // ---------------- input qualification ----------------
  // high-voltage level on the shutdown pin is detected off-block as its own input
  assign bypass = test_level_detect;
  // direct path: raw comparator, no clock, so the reaction is not delayed
  assign ov_now = trip_raw.ov & ~bypass;
  // toggle = seen asserted, now released
  assign toggle_done = shutdown_seen_ff & ~shutdown_in;
  assign blanked = (blank_ff != BLK_IDLE);

  // ---------------- transition blanking ----------------
  // settle window counts slew ticks after the slew controller goes quiet;
  // a fresh transition during the window restarts the whole blanking
  always_comb begin
    nxt_blank = blank_ff;
    nxt_blank_cnt = blank_cnt_ff;
    case (blank_ff)
      BLK_IDLE: begin
        if (transition_busy) begin
          nxt_blank = BLK_SLEW;
        end
      end
      BLK_SLEW: begin
        if (!transition_busy) begin
          nxt_blank = BLK_SETTLE;
          nxt_blank_cnt = 6'h00;
        end
      end
      BLK_SETTLE: begin
        if (transition_busy) begin
          nxt_blank = BLK_SLEW;
        end else if (slew_tick) begin
          if (blank_cnt_ff == `OFPL_BLANK_TICKS - 6'h01) begin
            nxt_blank = BLK_IDLE;
          end
          nxt_blank_cnt = blank_cnt_ff + 6'h01;
        end
      end
      default: begin
        nxt_blank = BLK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      blank_ff <= BLK_IDLE;
      blank_cnt_ff <= 6'h00;
    end else begin
      blank_ff <= nxt_blank;
      blank_cnt_ff <= nxt_blank_cnt;
    end
  end

  // ---------------- fault latch ----------------
  // only synchronised levels reach the latch
  assign fault_set.ov = trip_sync.ov;
  assign fault_set.uv = trip_sync.uv & ~blanked;
  assign fault_set.th = trip_sync.th;

  // a trip present at the toggle release wins and re-latches at once
  always_comb begin
    nxt_fault = fault_ff;
    if (bypass) begin
      nxt_fault = '0;
    end else begin
      if (toggle_done) begin
        nxt_fault = '0;
      end
      nxt_fault = nxt_fault | fault_set;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_ff <= '0;
      shutdown_seen_ff <= 1'b0;
      test_ff <= 1'b0;
    end else begin
      fault_ff <= nxt_fault;
      shutdown_seen_ff <= shutdown_in;
      test_ff <= bypass;
    end
  end

  // ---------------- gate drive forcing ----------------
  assign any_fault = fault_ff.ov | fault_ff.uv | fault_ff.th;
  // ov discharges through the low side; thermal does the same
  assign force_low = fault_ff.ov | fault_ff.th;
  assign off_state = any_fault | shutdown_in;

  // high side also blocked while the modulator asks for the low side,
  // so a bad request pair can never shoot through
  always_comb begin
    if (force_low) begin
      nxt_low = 1'b1;
      nxt_high = 1'b0;
    end else if (off_state) begin
      nxt_low = 1'b0;
      nxt_high = 1'b0;
    end else begin
      nxt_low = pwm_low_req;
      nxt_high = pwm_high_req & ~pwm_low_req;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      low_ff <= 1'b0;
      high_ff <= 1'b0;
    end else begin
      low_ff <= nxt_low;
      high_ff <= nxt_high;
    end
  end

  assign low_side_drive = low_ff;
  assign high_side_drive = high_ff;
  assign modulator_enable = ~off_state;

  // ---------------- power-good and clock-gate request ----------------
  // a latched overvoltage overrides blanking; otherwise the pair freezes while blanked
  always_comb begin
    nxt_pg = pg_ff;
    nxt_clkreq = clkreq_ff;
    if (fault_ff.ov) begin
      nxt_pg = 1'b0;
      nxt_clkreq = 1'b1;
    end else if (!blanked) begin
      nxt_pg = regulator_ok & ~any_fault;
      nxt_clkreq = ~(regulator_ok & ~any_fault);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pg_ff <= 1'b0;
      clkreq_ff <= 1'b1;
    end else begin
      pg_ff <= nxt_pg;
      clkreq_ff <= nxt_clkreq;
    end
  end

  // overvoltage path bypasses the flops so no clock edge is needed
  assign cpu_power_good = pg_ff & ~ov_now;
  assign clock_gate_request = clkreq_ff | ov_now;

  // ---------------- current limit mode ----------------
  // select pin is a strap level, sampled every cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      limit_fixed_ff <= 1'b0;
    end else begin
      limit_fixed_ff <= current_limit_select;
    end
  end

  assign current_limit_fixed = limit_fixed_ff;

  // ---------------- events and interrupt ----------------
  // rising edges of each latched fault and of test mode entry
  assign events[`OFPL_EV_OV] = nxt_fault.ov & ~fault_ff.ov;
  assign events[`OFPL_EV_UV] = nxt_fault.uv & ~fault_ff.uv;
  assign events[`OFPL_EV_TH] = nxt_fault.th & ~fault_ff.th;
  assign events[`OFPL_EV_TEST] = bypass & ~test_ff;

  // register write decode
  assign wr_status = reg_wr & (reg_addr == `OFPL_ADDR_STATUS);
  assign wr_mask = reg_wr & (reg_addr == `OFPL_ADDR_MASK);
  assign wr_div = reg_wr & (reg_addr == `OFPL_ADDR_SLEWDIV);

  // write one to clear; a new event in the same cycle keeps its bit
  assign nxt_status = (status_ff & ~(wr_status ? reg_wdata[`OFPL_EV_W-1:0] :
                      `OFPL_STATUS_RST)) | events;

  always_ff @(posedge clk) begin
    if (srst) begin
      status_ff <= `OFPL_STATUS_RST;
      mask_ff <= `OFPL_MASK_RST;
      slew_div_ff <= `OFPL_SLEW_DIV_RST;
    end else begin
      status_ff <= nxt_status;
      if (wr_mask) begin
        mask_ff <= reg_wdata[`OFPL_EV_W-1:0];
      end
      if (wr_div) begin
        slew_div_ff <= reg_wdata[15:0];
      end
    end
  end

  assign irq = |(status_ff & mask_ff);

  // ---------------- register read ----------------
  assign state_word = {~off_state, shutdown_in, limit_fixed_ff, blanked,
                       test_ff, fault_ff.th, fault_ff.uv, fault_ff.ov};

  // unmapped offsets read zero
  assign rd_mux =
    (reg_addr == `OFPL_ADDR_STATUS) ? ofpl_zext8({4'h0, status_ff}) :
    (reg_addr == `OFPL_ADDR_MASK) ? ofpl_zext8({4'h0, mask_ff}) :
    (reg_addr == `OFPL_ADDR_STATE) ? ofpl_zext8(state_word) :
    (reg_addr == `OFPL_ADDR_SLEWDIV) ? {16'h0000, slew_div_ff} :
    `OFPL_UNMAPPED;

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule

// ---- verif/ofpl_checker.sv ----
// port checker of the fault latch, bound to the core
// assumes one clock domain and srst as the only reset
`timescale 1ns/100ps
module ofpl_checker
  import ofpl_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire ofpl_trip_s trip_raw,
  input wire logic shutdown_in,
  input wire logic test_level_detect,
  input wire logic current_limit_select,
  input wire logic transition_busy,
  input wire logic modulator_enable,
  input wire logic low_side_drive,
  input wire logic high_side_drive,
  input wire logic cpu_power_good,
  input wire logic clock_gate_request,
  input wire logic current_limit_fixed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // a trip held long enough to cross the synchroniser and latch
  sequence ov_held;
    (trip_raw.ov && !shutdown_in && !test_level_detect) [*5];
  endsequence
  sequence th_held;
    (trip_raw.th && !shutdown_in && !test_level_detect) [*5];
  endsequence
  sequence quiet;
    !shutdown_in && !test_level_detect && trip_raw == 3'h0;
  endsequence
  // raw overvoltage acts without the clock
  a_ov_pg_drop: assert property (trip_raw.ov && !test_level_detect |->
    !cpu_power_good && clock_gate_request) else $error("ov did not drop power good");
  a_ov_trip_off: assert property (ov_held |=> !modulator_enable)
    else $error("ov did not shut down");
  a_ov_low_latch: assert property (ov_held ##1 quiet [*4] |=>
    low_side_drive && !high_side_drive) else $error("low side not latched");
  a_th_drive_force: assert property (th_held |=>
    low_side_drive && !high_side_drive) else $error("thermal drives wrong");
  a_th_stay_off: assert property (th_held ##1 quiet [*6] |=> !modulator_enable)
    else $error("thermal fault not held");
  a_bypass_clear: assert property ((test_level_detect && !shutdown_in) [*2]
    |-> modulator_enable) else $error("bypass left fault set");
  a_toggle_clear: assert property ((trip_raw == 3'h0 && !test_level_detect) [*3]
    ##0 shutdown_in ##1 quiet [*2] |=> modulator_enable == !shutdown_in)
    else $error("toggle did not clear");
  a_sync_late: assert property ((trip_raw == 3'h0) [*2] ##1 (trip_raw != 3'h0
    && modulator_enable && !shutdown_in) ##1 !shutdown_in |-> modulator_enable)
    else $error("trip acted before sync");
  a_limit_copy: assert property ($stable(current_limit_select) && !$past(srst)
    |-> current_limit_fixed == current_limit_select) else $error("limit select copy wrong");
  // entry edge may still update, so the freeze is judged one cycle in
  a_pg_frozen: assert property ((transition_busy && modulator_enable
    && trip_raw == 3'h0) [*3] |-> $stable(cpu_power_good) && $stable(clock_gate_request))
    else $error("power good moved while blanked");
endmodule

bind ofpl_core ofpl_checker i_ofpl_checker (.clk(clk), .srst(srst), .trip_raw(trip_raw),
  .shutdown_in(shutdown_in), .test_level_detect(test_level_detect),
  .current_limit_select(current_limit_select), .transition_busy(transition_busy),
  .modulator_enable(modulator_enable), .low_side_drive(low_side_drive),
  .high_side_drive(high_side_drive), .cpu_power_good(cpu_power_good),
  .clock_gate_request(clock_gate_request), .current_limit_fixed(current_limit_fixed));

// ---- verif/ofpl_plant.sv ----
// far side model: comparators, test-level sense, power-good source
// assumes the bench commands faults off the clock edge
`timescale 1ns/100ps
module ofpl_plant
  import ofpl_pkg::*;
(
  input wire logic low_side_drive,
  input wire logic high_side_drive,
  input wire ofpl_trip_s fault_cmd,
  input wire logic hv_req,
  input wire logic pok_fail,
  output ofpl_trip_s trip_raw,
  output logic test_level_detect,
  output logic regulator_ok,
  output logic shoot_through
);
  // comparator levels follow the commanded fault
  assign trip_raw = fault_cmd;
  assign test_level_detect = hv_req;
  assign regulator_ok = !pok_fail;
  // both switches on would short the input supply
  assign shoot_through = low_side_drive && high_side_drive;
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench of the fault latch with its plant model
// assumes the checker is bound to the core by its own file
`timescale 1ns/100ps
`include "ofpl_regs.svh"
module tb_top
  import ofpl_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, shutdown_in = 1'b0, current_limit_select = 1'b0;
  logic transition_busy = 1'b0, hv_req = 1'b0, pok_fail = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic pwm_high_req = 1'b0, pwm_low_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  ofpl_trip_s fault_cmd = 3'h0, trip_raw;
  logic test_level_detect, regulator_ok, shoot_through, low_side_drive, high_side_drive;
  logic modulator_enable, cpu_power_good, clock_gate_request, current_limit_fixed, irq;
  int fails = 0, cmp_count = 0, cycles = 0;

  ofpl_core i_ofpl_core (.clk(clk), .srst(srst), .trip_raw(trip_raw),
    .shutdown_in(shutdown_in), .test_level_detect(test_level_detect),
    .current_limit_select(current_limit_select), .transition_busy(transition_busy),
    .regulator_ok(regulator_ok), .pwm_high_req(pwm_high_req), .pwm_low_req(pwm_low_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .low_side_drive(low_side_drive),
    .high_side_drive(high_side_drive), .modulator_enable(modulator_enable),
    .cpu_power_good(cpu_power_good), .clock_gate_request(clock_gate_request),
    .current_limit_fixed(current_limit_fixed), .irq(irq));
  ofpl_plant i_ofpl_plant (.low_side_drive(low_side_drive),
    .high_side_drive(high_side_drive), .fault_cmd(fault_cmd), .hv_req(hv_req),
    .pok_fail(pok_fail), .trip_raw(trip_raw), .test_level_detect(test_level_detect),
    .regulator_ok(regulator_ok), .shoot_through(shoot_through));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic summarize();
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk_reg(nm, e, reg_rdata);
  endtask
  // shutdown high for one cycle, then low
  task automatic toggle();
    @(posedge clk) shutdown_in <= 1'b1;
    @(posedge clk) shutdown_in <= 1'b0;
    cyc(3);
  endtask
  task automatic set_in(input ofpl_trip_s f, input logic b, input logic h, input logic p);
    @(posedge clk);
    fault_cmd <= f;
    transition_busy <= b;
    hv_req <= h;
    pok_fail <= p;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd_chk(`OFPL_ADDR_STATE, 32'h80, "state");
    rd_chk(`OFPL_ADDR_MASK, 32'h0, "mask");
    rd_chk(`OFPL_ADDR_SLEWDIV, 32'h9C, "slewdiv");
    rd_chk(8'h10, 32'h0, "unmapped");
    wr(`OFPL_ADDR_SLEWDIV, 32'h1);
    wr(`OFPL_ADDR_MASK, 32'hF);
    // the short divide only applies once the reset period has wrapped
    cyc(150);
    rd_chk(`OFPL_ADDR_MASK, 32'hF, "mask");
    // overvoltage: immediate outputs, then latched low side
    set_in(3'h4, 1'b0, 1'b0, 1'b0);
    #1 chk_bit("pg", 1'b0, cpu_power_good);
    chk_bit("clkreq", 1'b1, clock_gate_request);
    cyc(5);
    chk_bit("low", 1'b1, low_side_drive);
    chk_bit("irq", 1'b1, irq);
    set_in(3'h0, 1'b0, 1'b0, 1'b0);
    cyc(6);
    chk_bit("low", 1'b1, low_side_drive);
    chk_bit("mod", 1'b0, modulator_enable);
    rd_chk(`OFPL_ADDR_STATUS, 32'h1, "status");
    toggle();
    chk_bit("mod", 1'b1, modulator_enable);
    wr(`OFPL_ADDR_STATUS, 32'h1);
    wr(`OFPL_ADDR_MASK, 32'h0);
    // high side requested from here on, so forcing it low is visible
    pwm_high_req <= 1'b1;
    // thermal, with its interrupt masked at first
    set_in(3'h1, 1'b0, 1'b0, 1'b0);
    cyc(5);
    chk_bit("low", 1'b1, low_side_drive);
    chk_bit("high", 1'b0, high_side_drive);
    chk_bit("irq", 1'b0, irq);
    set_in(3'h0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk_bit("mod", 1'b0, modulator_enable);
    wr(`OFPL_ADDR_MASK, 32'h4);
    #1 chk_bit("irq", 1'b1, irq);
    toggle();
    chk_bit("mod", 1'b1, modulator_enable);
    wr(`OFPL_ADDR_STATUS, 32'h4);
    #1 chk_bit("irq", 1'b0, irq);
    // undervoltage during a transition and its 32-tick tail
    set_in(3'h2, 1'b1, 1'b0, 1'b0);
    cyc(10);
    rd_chk(`OFPL_ADDR_STATE, 32'h90, "state");
    set_in(3'h2, 1'b0, 1'b0, 1'b0);
    cyc(10);
    chk_bit("mod", 1'b1, modulator_enable);
    cyc(40);
    chk_bit("mod", 1'b0, modulator_enable);
    chk_bit("low", 1'b0, low_side_drive);
    chk_bit("high", 1'b0, high_side_drive);
    set_in(3'h0, 1'b0, 1'b0, 1'b0);
    cyc(6);
    chk_bit("mod", 1'b0, modulator_enable);
    toggle();
    // power good frozen through a transition
    set_in(3'h0, 1'b1, 1'b0, 1'b0);
    set_in(3'h0, 1'b1, 1'b0, 1'b1);
    cyc(10);
    chk_bit("pg", 1'b1, cpu_power_good);
    set_in(3'h0, 1'b0, 1'b0, 1'b1);
    cyc(10);
    chk_bit("clkreq", 1'b0, clock_gate_request);
    cyc(40);
    chk_bit("pg", 1'b0, cpu_power_good);
    chk_bit("clkreq", 1'b1, clock_gate_request);
    // bypass test mode clears a latched overvoltage
    set_in(3'h4, 1'b0, 1'b0, 1'b0);
    cyc(5);
    set_in(3'h4, 1'b0, 1'b1, 1'b0);
    cyc(3);
    chk_bit("mod", 1'b1, modulator_enable);
    chk_bit("pg", 1'b1, cpu_power_good);
    rd_chk(`OFPL_ADDR_STATUS, 32'hB, "status");
    // trip removed while still bypassed, so nothing re-latches on exit
    set_in(3'h0, 1'b0, 1'b1, 1'b0);
    cyc(3);
    set_in(3'h0, 1'b0, 1'b0, 1'b0);
    wr(`OFPL_ADDR_STATUS, 32'hF);
    // fixed current limit selected
    @(posedge clk);
    current_limit_select <= 1'b1;
    pwm_low_req <= 1'b1;
    cyc(2);
    chk_bit("limit", 1'b1, current_limit_fixed);
    rd_chk(`OFPL_ADDR_STATE, 32'hA0, "state");
    chk_bit("shoot", 1'b0, shoot_through);
    // supply cycle clears a latched overvoltage
    set_in(3'h4, 1'b0, 1'b0, 1'b0);
    set_in(3'h0, 1'b0, 1'b0, 1'b0);
    cyc(4);
    chk_bit("mod", 1'b0, modulator_enable);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    cyc(2);
    chk_bit("mod", 1'b1, modulator_enable);
    rd_chk(`OFPL_ADDR_STATE, 32'hA0, "state");
    summarize();
  end
endmodule
